// file: shared/sasc_pkg.sv
// shared constants for the short-cycle converter sequencer and its host
package sasc_pkg;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          WORD_BITS       = 10;
    localparam int          SHORT_BITS      = 8;
    localparam int          CNT_W           = 4;
    localparam int          DIV_W           = 12;
    localparam int          WAIT_W          = 12;
    localparam int          FULL_TERM_PULSE = WORD_BITS + 1;
    localparam int          SHORT_TERM_PULSE = SHORT_BITS + 1;
    localparam int          CO_HALF_NS      = 1100;
    localparam int          CO_HALF_CYC     = CO_HALF_NS / CLK_PERIOD_NS;
    localparam int          CUT_MIN_NS      = 900;
    localparam int          CUT_MIN_CYC     = (CUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ACQ_NS          = 2000;
    localparam int          ACQ_CYC         = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          REQ_NS          = 250;
    localparam int          REQ_CYC         = (REQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0]  SPURIOUS_MASK   = 10'h2aa;
    localparam logic [9:0]  RESULT_RST      = 10'h000;
endpackage

// file: shared/sasc_link_if.sv
// link between the converter sequencer and the host that drives it
`timescale 1ns/1ps
`default_nettype none
interface sasc_link_if;
    logic conversionRequest;
    logic wordLengthCut;
    logic externalClockIn;
    logic busy;
    logic bitClockOut;
    logic serialBitOutN;

    modport device_mp (
        input  conversionRequest,
        input  wordLengthCut,
        input  externalClockIn,
        output busy,
        output bitClockOut,
        output serialBitOutN
    );

    modport host_mp (
        output conversionRequest,
        output wordLengthCut,
        input  busy,
        input  bitClockOut,
        input  serialBitOutN
    );
endinterface
`default_nettype wire

// file: hdl/sasc_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sasc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    if (WIDTH < 1) begin : g_chk
        $error("sasc_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

// file: hdl/sasc_device.sv
// converter sequencer: word length control, busy flag, bit clock and serial bits
// Operation
// - host holds cut high for full ten bits
// - cut tied low gives eight-bit results
// - host pulls cut low after sampling bit N
// - terminate after bit N at pulse N+1
// - result after odd length is spurious
// - host cut fall in low phase, 900ns
// - cut back high a cycle before reuse
// - cut low at pulse eight forces eight bits
// - idle cut fall terminates next conversion early
// - busy high throughout each conversion
// - host waits 2us after busy falls
// - request pulse starts a conversion
// - bits resolved msb first to lsb
// - serial bit at bit clock rise, low means one
// - request still high restarts immediately
`timescale 1ns/1ps
`default_nettype none
module sasc_device #(
    parameter int CO_HALF_P = sasc_pkg::CO_HALF_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    sasc_link_if.device_mp                     link,
    input  wire logic                          useExtClk,
    input  wire logic [sasc_pkg::WORD_BITS-1:0] sampleValue,
    output logic      [sasc_pkg::WORD_BITS-1:0] resultData,
    output logic      [sasc_pkg::CNT_W-1:0]     resultLen,
    output logic                               resultValid,
    output logic                               resultSpurious
);
    import sasc_pkg::*;

    typedef enum logic {ST_IDLE, ST_RUN} sasc_dev_state_t;

    if (CO_HALF_P < 2 || CO_HALF_P >= (1 << DIV_W)) begin : g_chk
        $error("sasc_device: CO_HALF_P out of range");
    end

    function automatic int unsigned bitIdx(input logic [CNT_W-1:0] pulse);
        bitIdx = WORD_BITS - int'(pulse);
    endfunction

    logic reqS;
    logic cutS;
    logic xclS;

    sasc_sync #(.WIDTH(3)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({link.conversionRequest, link.wordLengthCut, link.externalClockIn}),
        .dout ({reqS, cutS, xclS})
    );

    // internal bit clock divider, free running so its phase never glitches
    logic [DIV_W-1:0] divCnt_ff;
    logic [DIV_W-1:0] nxt_divCnt;
    logic             intPhase_ff;
    logic             nxt_intPhase;
    logic             phasePrev_ff;
    logic             nxt_phasePrev;
    logic             phase;
    logic             rise;

    always_comb begin
        nxt_divCnt   = divCnt_ff + DIV_W'(1);
        nxt_intPhase = intPhase_ff;
        if (divCnt_ff == DIV_W'(CO_HALF_P - 1)) begin
            nxt_divCnt   = '0;
            nxt_intPhase = ~intPhase_ff;
        end
        phase         = useExtClk ? xclS : intPhase_ff;
        nxt_phasePrev = phase;
        rise          = phase & ~phasePrev_ff;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_ff    <= '0;
            intPhase_ff  <= 1'b0;
            phasePrev_ff <= 1'b0;
        end else begin
            divCnt_ff    <= nxt_divCnt;
            intPhase_ff  <= nxt_intPhase;
            phasePrev_ff <= nxt_phasePrev;
        end
    end

    // sequencer
    sasc_dev_state_t           state_ff;
    sasc_dev_state_t           nxt_state;
    logic [CNT_W-1:0]          pulseCnt_ff;
    logic [CNT_W-1:0]          nxt_pulseCnt;
    logic                      busy_ff;
    logic                      nxt_busy;
    logic                      bitOutN_ff;
    logic                      nxt_bitOutN;
    logic                      bitClk_ff;
    logic                      nxt_bitClk;
    logic [WORD_BITS-1:0]      word_ff;
    logic [WORD_BITS-1:0]      nxt_word;
    logic [WORD_BITS-1:0]      acc_ff;
    logic [WORD_BITS-1:0]      nxt_acc;
    logic                      cutPrev_ff;
    logic                      nxt_cutPrev;
    logic                      cutPend_ff;
    logic                      nxt_cutPend;
    logic                      spurNext_ff;
    logic                      nxt_spurNext;
    logic                      curSpur_ff;
    logic                      nxt_curSpur;
    logic [WORD_BITS-1:0]      resData_ff;
    logic [WORD_BITS-1:0]      nxt_resData;
    logic [CNT_W-1:0]          resLen_ff;
    logic [CNT_W-1:0]          nxt_resLen;
    logic                      resValid_ff;
    logic                      nxt_resValid;
    logic                      resSpur_ff;
    logic                      nxt_resSpur;
    logic [CNT_W-1:0]          pulseNext;
    logic                      term;

    always_comb begin
        nxt_state    = state_ff;
        nxt_pulseCnt = pulseCnt_ff;
        nxt_busy     = busy_ff;
        nxt_bitOutN  = bitOutN_ff;
        nxt_word     = word_ff;
        nxt_acc      = acc_ff;
        nxt_cutPrev  = cutS;
        nxt_cutPend  = cutPend_ff;
        nxt_spurNext = spurNext_ff;
        nxt_curSpur  = curSpur_ff;
        nxt_resData  = resData_ff;
        nxt_resLen   = resLen_ff;
        nxt_resValid = 1'b0;
        nxt_resSpur  = resSpur_ff;
        pulseNext    = pulseCnt_ff + CNT_W'(1);
        term         = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (reqS) begin
                    nxt_state    = ST_RUN;
                    nxt_busy     = 1'b1;
                    nxt_pulseCnt = '0;
                    nxt_acc      = '0;
                    // the word after an odd length comes out corrupted
                    nxt_word     = spurNext_ff ? (sampleValue ^ SPURIOUS_MASK) : sampleValue;
                    nxt_curSpur  = spurNext_ff;
                    nxt_spurNext = 1'b0;
                end
            end
            ST_RUN: begin
                if (rise) begin
                    term = cutPend_ff
                        | (pulseNext == CNT_W'(SHORT_TERM_PULSE) && !cutS)
                        | (pulseNext == CNT_W'(FULL_TERM_PULSE));
                    if (term) begin
                        nxt_state    = ST_IDLE;
                        nxt_busy     = 1'b0;
                        nxt_bitOutN  = 1'b1;
                        nxt_cutPend  = 1'b0;
                        nxt_resData  = acc_ff;
                        nxt_resLen   = pulseCnt_ff;
                        nxt_resValid = 1'b1;
                        nxt_resSpur  = curSpur_ff;
                        nxt_spurNext = pulseCnt_ff[0];
                    end else begin
                        nxt_pulseCnt = pulseNext;
                        nxt_bitOutN  = ~word_ff[bitIdx(pulseNext)];
                        nxt_acc[bitIdx(pulseNext)] = word_ff[bitIdx(pulseNext)];
                    end
                end
            end
        endcase
        // a cut edge wins over the clear above, even while idle
        if (cutPrev_ff && !cutS) begin
            nxt_cutPend = 1'b1;
        end
        // the clock is shown only from the first counted pulse, so no runt appears
        nxt_bitClk = nxt_busy && (nxt_pulseCnt != '0) && phase;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff    <= ST_IDLE;
            pulseCnt_ff <= '0;
            busy_ff     <= 1'b0;
            bitOutN_ff  <= 1'b1;
            bitClk_ff   <= 1'b0;
            word_ff     <= RESULT_RST;
            acc_ff      <= RESULT_RST;
            cutPrev_ff  <= 1'b0;
            cutPend_ff  <= 1'b0;
            spurNext_ff <= 1'b0;
            curSpur_ff  <= 1'b0;
            resData_ff  <= RESULT_RST;
            resLen_ff   <= '0;
            resValid_ff <= 1'b0;
            resSpur_ff  <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            pulseCnt_ff <= nxt_pulseCnt;
            busy_ff     <= nxt_busy;
            bitOutN_ff  <= nxt_bitOutN;
            bitClk_ff   <= nxt_bitClk;
            word_ff     <= nxt_word;
            acc_ff      <= nxt_acc;
            cutPrev_ff  <= nxt_cutPrev;
            cutPend_ff  <= nxt_cutPend;
            spurNext_ff <= nxt_spurNext;
            curSpur_ff  <= nxt_curSpur;
            resData_ff  <= nxt_resData;
            resLen_ff   <= nxt_resLen;
            resValid_ff <= nxt_resValid;
            resSpur_ff  <= nxt_resSpur;
        end
    end

    assign link.busy          = busy_ff;
    assign link.bitClockOut   = bitClk_ff;
    assign link.serialBitOutN = bitOutN_ff;
    assign resultData         = resData_ff;
    assign resultLen          = resLen_ff;
    assign resultValid        = resValid_ff;
    assign resultSpurious     = resSpur_ff;
endmodule
`default_nettype wire

// file: hdl/sasc_host.sv
// host end: requests conversions, cuts word length, gathers serial bits
`timescale 1ns/1ps
`default_nettype none
module sasc_host (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    sasc_link_if.host_mp                       link,
    input  wire logic                          startReq,
    input  wire logic [sasc_pkg::CNT_W-1:0]     wordLen,
    output logic                               hostReady,
    output logic      [sasc_pkg::WORD_BITS-1:0] dataWord,
    output logic      [sasc_pkg::CNT_W-1:0]     dataLen,
    output logic                               dataValid
);
    import sasc_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT, H_CONVERSION_REQUEST, H_ACQ} sasc_host_state_t;

    logic busyS;
    logic clkS;
    logic serS;

    sasc_sync #(.WIDTH(3)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({link.busy, link.bitClockOut, link.serialBitOutN}),
        .dout ({busyS, clkS, serS})
    );

    sasc_host_state_t     state_ff;
    sasc_host_state_t     nxt_state;
    logic [WAIT_W-1:0]    cnt_ff;
    logic [WAIT_W-1:0]    nxt_cnt;
    logic [WAIT_W-1:0]    cutCnt_ff;
    logic [WAIT_W-1:0]    nxt_cutCnt;
    logic                 req_ff;
    logic                 nxt_req;
    logic                 cut_ff;
    logic                 nxt_cut;
    logic                 clkPrev_ff;
    logic [CNT_W-1:0]     lenReq_ff;
    logic [CNT_W-1:0]     nxt_lenReq;
    logic [CNT_W-1:0]     fallCnt_ff;
    logic [CNT_W-1:0]     nxt_fallCnt;
    logic [WORD_BITS-1:0] acc_ff;
    logic [WORD_BITS-1:0] nxt_acc;
    logic [WORD_BITS-1:0] word_ff;
    logic [WORD_BITS-1:0] nxt_word;
    logic [CNT_W-1:0]     len_ff;
    logic [CNT_W-1:0]     nxt_len;
    logic                 valid_ff;
    logic                 nxt_valid;

    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff + WAIT_W'(1);
        nxt_req     = req_ff;
        nxt_cut     = cut_ff;
        nxt_cutCnt  = cutCnt_ff;
        nxt_lenReq  = lenReq_ff;
        nxt_fallCnt = fallCnt_ff;
        nxt_acc     = acc_ff;
        nxt_word    = word_ff;
        nxt_len     = len_ff;
        nxt_valid   = 1'b0;
        // cut stays low long enough, then returns high well before reuse
        if (!cut_ff) begin
            nxt_cutCnt = cutCnt_ff + WAIT_W'(1);
            if (cutCnt_ff == WAIT_W'(CUT_MIN_CYC - 1)) begin
                nxt_cut = 1'b1;
            end
        end
        // request timer runs on through the wait, so the request still drops after busy is seen
        if (req_ff && cnt_ff == WAIT_W'(REQ_CYC - 1)) begin
            nxt_req = 1'b0;
        end
        unique case (state_ff)
            H_IDLE: begin
                if (startReq) begin
                    nxt_state  = H_REQ;
                    nxt_req    = 1'b1;
                    nxt_cnt    = '0;
                    nxt_lenReq = wordLen;
                end
            end
            H_REQ: begin
                nxt_state = H_WAIT;
            end
            H_WAIT: begin
                if (busyS) begin
                    nxt_state   = H_CONVERSION_REQUEST;
                    nxt_fallCnt = '0;
                    nxt_acc     = '0;
                end
            end
            H_CONVERSION_REQUEST: begin
                if (!busyS) begin
                    nxt_state = H_ACQ;
                    nxt_cnt   = '0;
                    nxt_word  = acc_ff;
                    nxt_len   = fallCnt_ff;
                    nxt_valid = 1'b1;
                end else if (clkPrev_ff && !clkS) begin
                    // data was set up at the rise; the fall is the safe sample point
                    nxt_fallCnt = fallCnt_ff + CNT_W'(1);
                    nxt_acc     = {acc_ff[WORD_BITS-2:0], ~serS};
                    if (fallCnt_ff + CNT_W'(1) == lenReq_ff && lenReq_ff < CNT_W'(WORD_BITS)) begin
                        nxt_cut    = 1'b0;
                        nxt_cutCnt = '0;
                    end
                end
            end
            H_ACQ: begin
                if (cnt_ff >= WAIT_W'(ACQ_CYC - 1) && cut_ff) begin
                    nxt_state = H_IDLE;
                end
            end
            default: nxt_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= H_IDLE;
            cnt_ff     <= '0;
            cutCnt_ff  <= '0;
            req_ff     <= 1'b0;
            cut_ff     <= 1'b1;
            clkPrev_ff <= 1'b0;
            lenReq_ff  <= '0;
            fallCnt_ff <= '0;
            acc_ff     <= RESULT_RST;
            word_ff    <= RESULT_RST;
            len_ff     <= '0;
            valid_ff   <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            cutCnt_ff  <= nxt_cutCnt;
            req_ff     <= nxt_req;
            cut_ff     <= nxt_cut;
            clkPrev_ff <= clkS;
            lenReq_ff  <= nxt_lenReq;
            fallCnt_ff <= nxt_fallCnt;
            acc_ff     <= nxt_acc;
            word_ff    <= nxt_word;
            len_ff     <= nxt_len;
            valid_ff   <= nxt_valid;
        end
    end

    assign link.conversionRequest = req_ff;
    assign link.wordLengthCut     = cut_ff;
    assign hostReady              = (state_ff == H_IDLE);
    assign dataWord               = word_ff;
    assign dataLen                = len_ff;
    assign dataValid              = valid_ff;
endmodule
`default_nettype wire

// file: verification/sasc_chk.sv
// link checker for the converter sequencer and its host
`timescale 1ns/1ps
`default_nettype none
module sasc_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic conversionRequest,
    input wire logic wordLengthCut,
    input wire logic externalClockIn,
    input wire logic busy,
    input wire logic bitClockOut,
    input wire logic serialBitOutN
);
    import sasc_pkg::*;
    logic [3:0] nPulse_ff;
    logic [3:0] nxt_nPulse;
    logic       cutLow_ff;
    logic       nxt_cutLow;
    logic       bitClkDly_ff;
    // pulses counted only while busy so a restart never inherits the old count
    always_comb begin
        nxt_nPulse = nPulse_ff;
        if (!busy) begin
            nxt_nPulse = 4'h0;
        end else if (bitClockOut && !bitClkDly_ff) begin
            nxt_nPulse = nPulse_ff + 4'h1;
        end
        nxt_cutLow = !wordLengthCut || (busy && cutLow_ff);
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nPulse_ff    <= 4'h0;
            cutLow_ff    <= 1'b0;
            bitClkDly_ff <= 1'b0;
        end else begin
            nPulse_ff    <= nxt_nPulse;
            cutLow_ff    <= nxt_cutLow;
            bitClkDly_ff <= bitClockOut;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_start;
        $rose(conversionRequest) && !busy |-> ##[2:4] busy;
    endproperty
    a_start: assert property (p_start)
        else $error("busy did not follow the request");
    property p_idle;
        !busy |-> serialBitOutN && !bitClockOut;
    endproperty
    a_idle: assert property (p_idle)
        else $error("bit lines not idle outside a conversion");
    property p_clk_busy;
        $rose(bitClockOut) |-> busy;
    endproperty
    a_clk_busy: assert property (p_clk_busy)
        else $error("bit clock pulse outside a conversion");
    property p_stable;
        bitClockOut && $past(bitClockOut) |-> $stable(serialBitOutN);
    endproperty
    a_stable: assert property (p_stable)
        else $error("serial bit moved while bit clock high");
    property p_max_bits;
        busy |-> nPulse_ff <= 4'ha;
    endproperty
    a_max_bits: assert property (p_max_bits)
        else $error("more than ten bit pulses");
    property p_full;
        $fell(busy) && !cutLow_ff |-> nPulse_ff == 4'ha;
    endproperty
    a_full: assert property (p_full)
        else $error("uncut conversion not ten bits long");
    property p_cut;
        busy && $fell(wordLengthCut) |-> !bitClockOut throughout (##[1:24] !busy);
    endproperty
    a_cut: assert property (p_cut)
        else $error("conversion not ended at next bit clock rise");
    property p_eight;
        busy && nPulse_ff == 4'h8 && !wordLengthCut && !$past(wordLengthCut, 2)
            |-> !$rose(bitClockOut);
    endproperty
    a_eight: assert property (p_eight)
        else $error("ninth bit produced with cut held low");
endmodule
`default_nettype wire

// file: verification/sasc_tb_top.sv
// self-checking bench joining the sequencer and its host over the link
`timescale 1ns/1ps
`default_nettype none
module sasc_tb_top;
    import sasc_pkg::*;
    // long half period keeps the host request shorter than one-bit conversions
    localparam int HALF  = 16;
    localparam int LIMIT = 20000;
    localparam logic [3:0] LENS [11] = '{4'h0, 4'h8, 4'h6, 4'h3, 4'h4, 4'h2,
                                         4'h1, 4'h5, 4'h9, 4'ha, 4'h0};
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       useExtClk = 1'b0;
    logic       startReq = 1'b0;
    logic [3:0] wordLen = 4'h0;
    logic [9:0] sampleValue = 10'h000;
    logic [9:0] resultData;
    logic [9:0] dataWord;
    logic [9:0] devData;
    logic [3:0] resultLen;
    logic [3:0] dataLen;
    logic [3:0] devLen;
    logic       resultValid;
    logic       resultSpurious;
    logic       hostReady;
    logic       dataValid;
    logic       devSpur;
    logic       prevOdd = 1'b0;
    int         miscompares = 0;
    int         nChecks = 0;
    int         cycles = 0;
    sasc_link_if link_if ();
    sasc_device #(.CO_HALF_P(HALF)) sasc_device_i (
        .clk(clk), .rstn(rstn), .link(link_if.device_mp), .useExtClk(useExtClk),
        .sampleValue(sampleValue), .resultData(resultData), .resultLen(resultLen),
        .resultValid(resultValid), .resultSpurious(resultSpurious));
    sasc_host sasc_host_i (
        .clk(clk), .rstn(rstn), .link(link_if.host_mp), .startReq(startReq),
        .wordLen(wordLen), .hostReady(hostReady), .dataWord(dataWord),
        .dataLen(dataLen), .dataValid(dataValid));
    sasc_chk sasc_chk_i (
        .clk(clk), .rstn(rstn), .conversionRequest(link_if.conversionRequest),
        .wordLengthCut(link_if.wordLengthCut), .externalClockIn(link_if.externalClockIn),
        .busy(link_if.busy), .bitClockOut(link_if.bitClockOut),
        .serialBitOutN(link_if.serialBitOutN));
    always #5 clk = ~clk;
    // odd start offset puts every link clock edge 2 ns after a clk rise, never on one
    initial begin
        link_if.externalClockIn = 1'b0;
        #37;
        forever #80 link_if.externalClockIn = ~link_if.externalClockIn;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (resultValid === 1'b1) begin
            devData <= resultData;
            devLen  <= resultLen;
            devSpur <= resultSpurious;
        end
        if (cycles == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic convert(input logic [3:0] wl, input logic [9:0] sv);
        int         n;
        logic [3:0] len;
        logic [9:0] exp;
        len = (wl == 4'h0 || wl >= 4'ha) ? 4'ha : wl;
        exp = prevOdd ? (sv ^ SPURIOUS_MASK) : sv;
        n = 0;
        while (hostReady !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) miscompares++;
        wordLen     <= wl;
        sampleValue <= sv;
        startReq    <= 1'b1;
        @(posedge clk);
        startReq <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dataValid !== 1'b1 && n < 2000);
        if (n >= 2000) miscompares++;
        check(dataWord, exp >> (4'ha - len));
        check({6'h0, dataLen}, {6'h0, len});
        check(devData, exp & ~(10'h3ff >> len));
        check({6'h0, devLen}, {6'h0, len});
        check({9'h0, devSpur}, {9'h0, prevOdd});
        prevOdd = len[0];
        $display("test length %0d done", len);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            convert(LENS[i], 10'h1b3 + 10'(i) * 10'h07d);
        end
        // clock source only changes in reset, the sequencer expects useExtClk static
        rstn      <= 1'b0;
        useExtClk <= 1'b1;
        prevOdd = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        convert(4'h0, 10'h2d6);
        convert(4'h2, 10'h13c);
        convert(4'h6, 10'h0f1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
